// File: bridge_bus_number_io_window_regs_test.sv
// Self-checking bench for the bus number and I/O window bank.
// Assumes cfg_host drives the configuration byte port.
`timescale 1ns/1ps
module bridge_bus_number_io_window_regs_test;
	reg        ref_clk = 0, sys_rst = 1, cfgT1Valid = 0, ioValid = 0;
	reg        pciClkEn = 0, burstActive = 0, grantHeld = 1;
	reg [7:0]  cfgT1Bus = 0, d, q[$];
	reg [31:0] ioAddr = 0;
	wire       cfgWr, cfgRd, cfgRdValid, ioForward, burstStop;
	wire [7:0] cfgAddr, cfgWrData, cfgRdData;
	wire [1:0] cfgT1Resp;
	integer    err_count = 0, checks = 0, cyc = 0, seed = 32'ha7efbddc, i;
	reg [7:0]  wa[8] = '{8'h19, 8'h1a, 8'h1c, 8'h1d, 8'h30, 8'h31, 8'h32, 8'h33};
	reg [7:0]  wd[8] = '{8'h05, 8'h09, 8'h20, 8'h40, 8'h01, 8'h00, 8'h01, 8'h00};
	reg [31:0] ia[8] = '{32'h11fff, 32'h12000, 32'h14fff, 32'h15000,
		32'h2000, 32'h13abc, 32'h21000, 32'h12001};
	cfg_host h (
		.ref_clk   (ref_clk),
		.cfgWr     (cfgWr),
		.cfgRd     (cfgRd),
		.cfgAddr   (cfgAddr),
		.cfgWrData (cfgWrData)
	);
	bridge_cfg_regs dut (
		.ref_clk     (ref_clk),
		.sys_rst     (sys_rst),
		.cfgWr       (cfgWr),
		.cfgRd       (cfgRd),
		.cfgAddr     (cfgAddr),
		.cfgWrData   (cfgWrData),
		.cfgRdData   (cfgRdData),
		.cfgRdValid  (cfgRdValid),
		.cfgT1Valid  (cfgT1Valid),
		.cfgT1Bus    (cfgT1Bus),
		.cfgT1Resp   (cfgT1Resp),
		.ioValid     (ioValid),
		.ioAddr      (ioAddr),
		.ioForward   (ioForward),
		.pciClkEn    (pciClkEn),
		.burstActive (burstActive),
		.grantHeld   (grantHeld),
		.burstStop   (burstStop)
	);
	initial forever #12.5 ref_clk = ~ref_clk;
	task conclude;
		$display("checks %0d err_count %0d", checks, err_count);
		if (err_count == 0 && checks > 0) $display("Testbench passed");
		else $display("Testbench failed");
		$finish;
	endtask
	task chk(input string n, input [7:0] e, s);
		checks++;
		if (e !== s) begin
			err_count++;
			$display("[ERR] %s exp %h got %h", n, e, s);
		end
	endtask
	task rd(input [7:0] a, e);
		q.push_back(e);
		h.req(0, a, 8'h00);
	endtask
	task rstReads;
		for (i = 8'h18; i < 8'h34; i++)
			if (i < 8'h1e || i > 8'h2f) rd(i, i[7:1] == 7'h0e ? 8'h01 : 8'h00);
	endtask
	always @(negedge ref_clk) begin
		cyc++;
		if (cfgRdValid === 1'b1) chk("rdata", q.pop_front(), cfgRdData);
		if (cyc == 2000) begin
			err_count++;
			conclude;
		end
	end
	initial begin
		repeat (10) @(negedge ref_clk);
		sys_rst = 0;
		rstReads;
		for (i = 8'h18; i < 8'h42; i++) if (i < 8'h1e || i[7:2] == 6'h0c || i == 8'h41) begin
			d = $random(seed);
			h.req(1, i, d);
			rd(i, i > 8'h33 ? 8'h00 : i[7:1] == 7'h0e ? {d[7:4], 4'h1} : d);
		end
		for (i = 0; i < 8; i++) h.req(1, wa[i], wd[i]);
		{cfgT1Valid, ioValid} = 2'h3;
		for (i = 0; i < 8; i++) begin
			cfgT1Bus = i + 3;
			ioAddr = ia[i];
			@(negedge ref_clk);
			chk("t1resp", i == 2 ? 1 : (i > 2 && i < 7) ? 2 : 0, cfgT1Resp);
			chk("iofwd", (8'ha6 >> i) & 1, ioForward);
		end
		h.req(1, 8'h1b, 8'h03);
		{burstActive, pciClkEn} = 2'h3;
		repeat (20) @(negedge ref_clk);
		chk("hold", 0, burstStop);
		grantHeld = 0;
		for (i = 0; i < 20 && burstStop !== 1'b1; i++) @(negedge ref_clk);
		chk("stop", 1, burstStop);
		burstActive = 0;
		repeat (3) @(negedge ref_clk);
		chk("idle", 0, burstStop);
		burstActive = 1;
		for (i = 0; i < 40 && burstStop !== 1'b1; i++) begin
			pciClkEn = !i[0];
			@(negedge ref_clk);
		end
		chk("latency", 7, i);
		{cfgT1Valid, ioValid, burstActive, pciClkEn} = 4'h0;
		sys_rst = 1;
		repeat (2) @(negedge ref_clk);
		chk("rstout", 0, {cfgRdValid, cfgT1Resp, ioForward, burstStop});
		sys_rst = 0;
		rstReads;
		repeat (3) @(negedge ref_clk);
		chk("pending", 0, q.size());
		conclude;
	end
endmodule // bridge_bus_number_io_window_regs_test

// File: bridge_cfg_defines.vh
// Constants for the bridge bus number and I/O window register bank.
// Assumes byte-wide configuration access at the header byte offsets.
// Function
// - Upstream bus index at 0x18, resets zero
// - Downstream bus index at 0x19, resets zero
// - Highest downstream index at 0x1a, resets zero
// - Downstream and highest indices steer type 1 configuration response
// - Burst timer at 0x1b, downstream clocks, zero
// - Base bits 7:4 give address 15:12
// - Limit bits 7:4 give 15:12, low FFF
// - Low nibbles of both read 1h
// - Bottom bits 31:16 from base-upper 0x30
// - Top bits 31:16 from limit-upper 0x32
// - Forward I/O when address inside window
`ifndef BRIDGE_CFG_DEFINES_VH
`define BRIDGE_CFG_DEFINES_VH
`define OFS_UP_BUS     8'h18
`define OFS_DN_BUS     8'h19
`define OFS_HI_BUS     8'h1a
`define OFS_BURST_TMR  8'h1b
`define OFS_IO_BOT     8'h1c
`define OFS_IO_TOP     8'h1d
`define OFS_IO_BOT_UP0 8'h30
`define OFS_IO_BOT_UP1 8'h31
`define OFS_IO_TOP_UP0 8'h32
`define OFS_IO_TOP_UP1 8'h33
`define RST_BYTE       8'h00
`define IO_WIDTH_CODE  4'h1
`define IO_LOW_BOT     12'h000
`define IO_LOW_TOP     12'hfff
`define CFG_RSP_NONE   2'h0
`define CFG_RSP_CONV   2'h1
`define CFG_RSP_PASS   2'h2
`define IO_BITS_RST    4'h0
`define IO_UP_RST      16'h0000
`define IO_FLD_MSB     7
`define IO_FLD_LSB     4
`define BYTE_LO_MSB    7
`define BYTE_LO_LSB    0
`define BYTE_HI_MSB    15
`define BYTE_HI_LSB    8
`define BUS_PAD        24'h000000
`define TMR_STEP       8'h01
`endif

// File: bridge_cfg_regs.v
// Type 1 header bus numbers, burst timer and I/O window registers.
// Assumes a byte-wide configuration port and same-clock request sources.
`timescale 1ns/1ps
`include "bridge_cfg_defines.vh"
module bridge_cfg_regs (
	// Clock and reset
	input  wire        ref_clk,
	input  wire        sys_rst,
	// Configuration byte port
	input  wire        cfgWr,
	input  wire        cfgRd,
	input  wire [7:0]  cfgAddr,
	input  wire [7:0]  cfgWrData,
	output reg  [7:0]  cfgRdData,
	output reg         cfgRdValid,
	// Type 1 configuration decode
	input  wire        cfgT1Valid,
	input  wire [7:0]  cfgT1Bus,
	output reg  [1:0]  cfgT1Resp,
	// I/O forwarding decode
	input  wire        ioValid,
	input  wire [31:0] ioAddr,
	output reg         ioForward,
	// Downstream burst control
	input  wire        pciClkEn,
	input  wire        burstActive,
	input  wire        grantHeld,
	output reg         burstStop
);
////////////////////////////////////////////////////////////////////////////////
reg  [7:0]  upBus_r;
reg  [7:0]  dnBus_r;
reg  [7:0]  hiBus_r;
reg  [7:0]  burstTmr_r;
reg  [3:0]  ioBotBits_r;
reg  [3:0]  ioTopBits_r;
reg  [15:0] ioBotUp_r;
reg  [15:0] ioTopUp_r;
reg  [7:0]  rdData_nxt;
wire [31:0] ioBottom;
wire [31:0] ioTop;
wire        stopNxt;
wire        wrUpBus;
wire        wrDnBus;
wire        wrHiBus;
wire        wrBurstTmr;
wire        wrIoBot;
wire        wrIoTop;
wire        wrIoBotUp0;
wire        wrIoBotUp1;
wire        wrIoTopUp0;
wire        wrIoTopUp1;
wire [31:0] busWide;
wire [31:0] dnBusWide;
wire [31:0] hiBusWide;

assign ioBottom = {ioBotUp_r, ioBotBits_r, `IO_LOW_BOT};
assign ioTop    = {ioTopUp_r, ioTopBits_r, `IO_LOW_TOP};
assign busWide   = {`BUS_PAD, cfgT1Bus};
assign dnBusWide = {`BUS_PAD, dnBus_r};
assign hiBusWide = {`BUS_PAD, hiBus_r};
////////////////////////////////////////////////////////////////////////////////
// Write strobes per register
assign wrUpBus    = cfgWr && (cfgAddr == `OFS_UP_BUS);
assign wrDnBus    = cfgWr && (cfgAddr == `OFS_DN_BUS);
assign wrHiBus    = cfgWr && (cfgAddr == `OFS_HI_BUS);
assign wrBurstTmr = cfgWr && (cfgAddr == `OFS_BURST_TMR);
assign wrIoBot    = cfgWr && (cfgAddr == `OFS_IO_BOT);
assign wrIoTop    = cfgWr && (cfgAddr == `OFS_IO_TOP);
assign wrIoBotUp0 = cfgWr && (cfgAddr == `OFS_IO_BOT_UP0);
assign wrIoBotUp1 = cfgWr && (cfgAddr == `OFS_IO_BOT_UP1);
assign wrIoTopUp0 = cfgWr && (cfgAddr == `OFS_IO_TOP_UP0);
assign wrIoTopUp1 = cfgWr && (cfgAddr == `OFS_IO_TOP_UP1);
////////////////////////////////////////////////////////////////////////////////
// Range compare shared by bus routing and the I/O window
function withinRange;
	input [31:0] value;
	input [31:0] low;
	input [31:0] high;
	begin
		withinRange = (value >= low) && (value <= high);
	end
endfunction
////////////////////////////////////////////////////////////////////////////////
// Register writes, one process per register
always @(posedge ref_clk) begin
	if (sys_rst)
		upBus_r <= `RST_BYTE;
	else if (wrUpBus)
		upBus_r <= cfgWrData;
end

always @(posedge ref_clk) begin
	if (sys_rst)
		dnBus_r <= `RST_BYTE;
	else if (wrDnBus)
		dnBus_r <= cfgWrData;
end

always @(posedge ref_clk) begin
	if (sys_rst)
		hiBus_r <= `RST_BYTE;
	else if (wrHiBus)
		hiBus_r <= cfgWrData;
end

always @(posedge ref_clk) begin
	if (sys_rst)
		burstTmr_r <= `RST_BYTE;
	else if (wrBurstTmr)
		burstTmr_r <= cfgWrData;
end

always @(posedge ref_clk) begin
	if (sys_rst)
		ioBotBits_r <= `IO_BITS_RST;
	else if (wrIoBot)
		ioBotBits_r <= cfgWrData[`IO_FLD_MSB:`IO_FLD_LSB];
end

always @(posedge ref_clk) begin
	if (sys_rst)
		ioTopBits_r <= `IO_BITS_RST;
	else if (wrIoTop)
		ioTopBits_r <= cfgWrData[`IO_FLD_MSB:`IO_FLD_LSB];
end

always @(posedge ref_clk) begin
	if (sys_rst) begin
		ioBotUp_r <= `IO_UP_RST;
	end else begin
		if (wrIoBotUp0)
			ioBotUp_r[`BYTE_LO_MSB:`BYTE_LO_LSB] <= cfgWrData;
		if (wrIoBotUp1)
			ioBotUp_r[`BYTE_HI_MSB:`BYTE_HI_LSB] <= cfgWrData;
	end
end

always @(posedge ref_clk) begin
	if (sys_rst) begin
		ioTopUp_r <= `IO_UP_RST;
	end else begin
		if (wrIoTopUp0)
			ioTopUp_r[`BYTE_LO_MSB:`BYTE_LO_LSB] <= cfgWrData;
		if (wrIoTopUp1)
			ioTopUp_r[`BYTE_HI_MSB:`BYTE_HI_LSB] <= cfgWrData;
	end
end
////////////////////////////////////////////////////////////////////////////////
// Register reads
always @* begin
	case (cfgAddr)
	`OFS_UP_BUS:     rdData_nxt = upBus_r;
	`OFS_DN_BUS:     rdData_nxt = dnBus_r;
	`OFS_HI_BUS:     rdData_nxt = hiBus_r;
	`OFS_BURST_TMR:  rdData_nxt = burstTmr_r;
	`OFS_IO_BOT:     rdData_nxt = {ioBotBits_r, `IO_WIDTH_CODE};
	`OFS_IO_TOP:     rdData_nxt = {ioTopBits_r, `IO_WIDTH_CODE};
	`OFS_IO_BOT_UP0: rdData_nxt = ioBotUp_r[`BYTE_LO_MSB:`BYTE_LO_LSB];
	`OFS_IO_BOT_UP1: rdData_nxt = ioBotUp_r[`BYTE_HI_MSB:`BYTE_HI_LSB];
	`OFS_IO_TOP_UP0: rdData_nxt = ioTopUp_r[`BYTE_LO_MSB:`BYTE_LO_LSB];
	`OFS_IO_TOP_UP1: rdData_nxt = ioTopUp_r[`BYTE_HI_MSB:`BYTE_HI_LSB];
	default:         rdData_nxt = `RST_BYTE;
	endcase
end

always @(posedge ref_clk) begin
	if (sys_rst) begin
		cfgRdData  <= `RST_BYTE;
		cfgRdValid <= 1'b0;
	end else begin
		cfgRdValid <= cfgRd;
		if (cfgRd)
			cfgRdData <= rdData_nxt;
	end
end
////////////////////////////////////////////////////////////////////////////////
// Type 1 configuration decode
always @(posedge ref_clk) begin
	if (sys_rst)
		cfgT1Resp <= `CFG_RSP_NONE;
	else if (!cfgT1Valid)
		cfgT1Resp <= `CFG_RSP_NONE;
	else if (cfgT1Bus == dnBus_r)
		cfgT1Resp <= `CFG_RSP_CONV;
	else if (withinRange(busWide, dnBusWide, hiBusWide))
		cfgT1Resp <= `CFG_RSP_PASS;
	else
		cfgT1Resp <= `CFG_RSP_NONE;
end
////////////////////////////////////////////////////////////////////////////////
// I/O window decode
always @(posedge ref_clk) begin
	if (sys_rst)
		ioForward <= 1'b0;
	else
		ioForward <= ioValid && withinRange(ioAddr, ioBottom, ioTop);
end
////////////////////////////////////////////////////////////////////////////////
// Burst latency
always @(posedge ref_clk) begin
	if (sys_rst)
		burstStop <= 1'b0;
	else
		burstStop <= stopNxt;
end

burst_timer uTimer (
	.ref_clk     (ref_clk),
	.sys_rst     (sys_rst),
	.clkEn       (pciClkEn),
	.burstActive (burstActive),
	.grantHeld   (grantHeld),
	.timerValue  (burstTmr_r),
	.burstStop   (stopNxt)
);
endmodule // bridge_cfg_regs

// File: bridge_cfg_regs_props.sv
// Port assertions for the bus number and I/O window bank.
// Assumes a bind into bridge_cfg_regs.
`timescale 1ns/1ps
module bridge_cfg_props (
	input       ref_clk, sys_rst, cfgWr, cfgRd, cfgRdValid,
	input       cfgT1Valid, ioValid, ioForward, burstActive, burstStop,
	input [7:0] cfgAddr, cfgWrData, cfgRdData,
	input [1:0] cfgT1Resp
);
	default clocking @(posedge ref_clk); endclocking
	default disable iff (sys_rst);
	property p_rv; cfgRd |=> cfgRdValid; endproperty
	a_rv: assert property (p_rv) else $error("no answer");
	property p_nr; !cfgRd |=> !cfgRdValid; endproperty
	a_nr: assert property (p_nr) else $error("stray answer");
	property p_ty; cfgRd && cfgAddr[7:1] == 7'h0e |=> cfgRdData[3:0] == 4'h1; endproperty
	a_ty: assert property (p_ty) else $error("type nibble");
	property p_wr; cfgWr && cfgAddr == 8'h19 ##1 !cfgWr ##1 cfgRd && !cfgWr && cfgAddr == 8'h19
		|=> cfgRdData == $past(cfgWrData, 3); endproperty
	a_wr: assert property (p_wr) else $error("readback");
	property p_rs; $fell(sys_rst) |-> !cfgRdValid && cfgT1Resp == 2'h0 && !ioForward; endproperty
	a_rs: assert property (p_rs) else $error("reset out");
	property p_t1; !cfgT1Valid |=> cfgT1Resp == 2'h0; endproperty
	a_t1: assert property (p_t1) else $error("t1 idle");
	property p_io; !ioValid |=> !ioForward; endproperty
	a_io: assert property (p_io) else $error("io idle");
	property p_bi; !burstActive [*3] |=> !burstStop; endproperty
	a_bi: assert property (p_bi) else $error("stop idle");
endmodule // bridge_cfg_props
bind bridge_cfg_regs bridge_cfg_props u_props (
	.ref_clk     (ref_clk),
	.sys_rst     (sys_rst),
	.cfgWr       (cfgWr),
	.cfgRd       (cfgRd),
	.cfgRdValid  (cfgRdValid),
	.cfgT1Valid  (cfgT1Valid),
	.ioValid     (ioValid),
	.ioForward   (ioForward),
	.burstActive (burstActive),
	.burstStop   (burstStop),
	.cfgAddr     (cfgAddr),
	.cfgWrData   (cfgWrData),
	.cfgRdData   (cfgRdData),
	.cfgT1Resp   (cfgT1Resp)
);

// File: burst_timer.v
// Downstream burst latency counter.
// Assumes clkEn marks one downstream bus clock in the core clock.
`timescale 1ns/1ps
`include "bridge_cfg_defines.vh"
module burst_timer (
	// Clock and reset
	input  wire       ref_clk,
	input  wire       sys_rst,
	// Control
	input  wire       clkEn,
	input  wire       burstActive,
	input  wire       grantHeld,
	input  wire [7:0] timerValue,
	// Result
	output reg        burstStop
);
reg [7:0] count_r;
always @(posedge ref_clk) begin
	if (sys_rst || !burstActive) begin
		count_r   <= `RST_BYTE;
		burstStop <= 1'b0;
	end else begin
		if (clkEn && count_r != timerValue)
			count_r <= count_r + `TMR_STEP;
		burstStop <= (count_r == timerValue) && !grantHeld;
	end
end
endmodule // burst_timer

// File: cfg_host.sv
// Root complex model issuing byte configuration requests.
// Assumes the caller starts each request from a falling edge.
`timescale 1ns/1ps
module cfg_host (
	input            ref_clk,
	output reg       cfgWr = 0, cfgRd = 0,
	output reg [7:0] cfgAddr = 0, cfgWrData = 0
);
	task req(input w, input [7:0] a, d);
		@(negedge ref_clk);
		{cfgWr, cfgRd, cfgAddr, cfgWrData} = {w, !w, a, d};
		@(negedge ref_clk);
		{cfgWr, cfgRd, cfgAddr, cfgWrData} = {2'h0, ~a, ~d};
	endtask
endmodule // cfg_host
